//--- sim/reset_warmup_sequencer_tb_top.sv
module reset_warmup_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, por_req = 0, pin_reset_n = 1;
   logic internal_req = 0, serial_prom_mode = 0, corrupt = 0;
   logic [6:0] internal_cause = 7'h00;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, nvm_rd, cpu_reset, periph_reset, cpu_fetch_vector;
   logic register_bank_select, interrupt_master_enable, interrupt_latch;
   logic interrupt_individual_enable, int_osc_en, ext_hf_osc_en;
   logic ext_lf_osc_en, prescaler_clr, watchdog_en, port_oe, vdet_en;
   logic [1:0] s_axi_bresp, s_axi_rresp, nvm_addr, r;
   logic [15:0] program_counter, stack_pointer, vector_addr;
   logic [7:0] nvm_data, trim_value;
   int errors = 0, checks_done = 0;
   reset_warmup_sequencer #(.WARMUP_COUNT(16)) dut_u (.*);
   trim_nvm_model nvm_u (.aclk(aclk), .nvm_addr(nvm_addr),
      .nvm_rd(nvm_rd), .corrupt(corrupt), .nvm_data(nvm_data));
   initial begin
      forever #2.5 aclk = ~aclk;
   end
   task automatic conclude;
      $display("errors=%0d checks=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wait_run;
      int n;
      for (n = 0; n < 100 && cpu_reset !== 1'h0; n++) tick(1);
      if (n == 100) begin
         errors++;
         conclude();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 50; n++) begin
         tick(1);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid === 1'h1) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 0;
      if (n == 50) begin
         errors++;
         conclude();
      end
      tick(1);
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (n = 0; n < 50; n++) begin
         tick(1);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid === 1'h1) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      if (n == 50) begin
         errors++;
         conclude();
      end
      tick(1);
   endtask
   task automatic pulse(input int k);
      case (k)
         0: por_req <= 1;
         1: pin_reset_n <= 0;
         default: internal_req <= 1;
      endcase
      tick(3);
      por_req <= 0;
      pin_reset_n <= 1;
      internal_req <= 0;
      tick(1);
   endtask
   task automatic t_por;
      por_req <= 1;
      tick(3);
      chk(cpu_reset, 1);
      chk(program_counter, 16'hfffe);
      chk(stack_pointer, 16'h00ff);
      chk(watchdog_en, 0);
      por_req <= 0;
      tick(12);
      chk(cpu_reset, 1);
      wait_run();
      chk(watchdog_en, 1);
      chk(trim_value, 8'h5a);
      $display("por done");
   endtask
   task automatic t_order;
      serial_prom_mode <= 1;
      por_req <= 1;
      pin_reset_n <= 0;
      tick(3);
      chk(program_counter, 16'h1ffe);
      por_req <= 0;
      tick(20);
      chk(cpu_reset, 1);
      pin_reset_n <= 1;
      serial_prom_mode <= 0;
      wait_run();
      $display("order done");
   endtask
   task automatic t_restart;
      internal_cause <= 7'h05;
      pulse(2);
      tick(7);
      internal_req <= 1;
      tick(1);
      internal_req <= 0;
      internal_cause <= 7'h00;
      tick(12);
      chk(cpu_reset, 1);
      wait_run();
      rd(12'h00c);
      chk(d & 32'h7f, 32'h05);
      wr(12'h000, 32'h1);
      wr(12'h00c, 32'h71);
      rd(12'h00c);
      chk(d, 32'h0);
      $display("restart done");
   endtask
   task automatic t_trim;
      corrupt <= 1;
      pulse(0);
      wait_run();
      rd(12'h004);
      chk(d[3], 1);
      corrupt <= 0;
      pulse(2);
      wait_run();
      rd(12'h004);
      chk(d[3], 1);
      pulse(0);
      wait_run();
      rd(12'h004);
      chk(d[4:2], 3'h1);
      $display("trim done");
   endtask
   task automatic t_vdet;
      wr(12'h000, 32'h2);
      chk(vdet_en, 1);
      pulse(2);
      wait_run();
      chk(vdet_en, 1);
      pulse(1);
      chk(vdet_en, 0);
      wait_run();
      s_axi_wstrb <= 4'h0;
      wr(12'h000, 32'h2);
      chk(vdet_en, 0);
      s_axi_wstrb <= 4'hf;
      wr(12'h010, 32'h0);
      chk(r, 2'h2);
      rd(12'h010);
      chk(d, 32'h0);
      chk(r, 2'h2);
      $display("vdet done");
   endtask
   initial begin
      tick(2);
      aresetn <= 1;
      tick(1);
      wait_run();
      t_por();
      t_order();
      t_restart();
      t_trim();
      t_vdet();
      conclude();
   end
endmodule

//--- sim/rwu_properties.sv
module rwu_properties (
   // Clock and requests
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic por_req,
   input wire logic pin_reset_n,
   input wire logic internal_req,
   input wire logic serial_prom_mode,
   // Observed state
   input wire logic nvm_rd,
   input wire logic cpu_reset,
   input wire logic periph_reset,
   input wire logic [15:0] program_counter,
   input wire logic [15:0] stack_pointer,
   input wire logic register_bank_select,
   input wire logic interrupt_master_enable,
   input wire logic interrupt_individual_enable,
   input wire logic interrupt_latch,
   input wire logic cpu_fetch_vector,
   input wire logic [15:0] vector_addr,
   input wire logic int_osc_en,
   input wire logic ext_hf_osc_en,
   input wire logic ext_lf_osc_en,
   input wire logic prescaler_clr,
   input wire logic watchdog_en,
   input wire logic port_oe,
   input wire logic vdet_en
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_any_req;
      por_req || !pin_reset_n || internal_req;
   endsequence
   sequence s_go;
      cpu_fetch_vector ##1 (!cpu_reset && !cpu_fetch_vector);
   endsequence
   property p_hold;
      s_any_req |=> cpu_reset && periph_reset;
   endproperty
   property p_pc;
      program_counter == (serial_prom_mode ? 16'h1ffe : 16'hfffe);
   endproperty
   property p_vec;
      cpu_fetch_vector |-> s_go and (vector_addr == 16'hfffe);
   endproperty
   property p_start;
      $fell(cpu_reset) |-> $past(cpu_fetch_vector);
   endproperty
   property p_sp;
      stack_pointer == 16'h00ff && !register_bank_select;
   endproperty
   property p_irq;
      !(interrupt_master_enable || interrupt_individual_enable
        || interrupt_latch);
   endproperty
   property p_osc;
      int_osc_en && !ext_hf_osc_en && !ext_lf_osc_en;
   endproperty
   property p_pre;
      prescaler_clr == cpu_reset;
   endproperty
   property p_wdt;
      watchdog_en == !cpu_reset && !port_oe;
   endproperty
   property p_vdet;
      internal_req && !por_req && pin_reset_n |=> $stable(vdet_en);
   endproperty
   property p_nvm;
      nvm_rd |-> cpu_reset;
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   a_pc: assert property (p_pc) else $error("pc");
   a_vec: assert property (p_vec) else $error("vector");
   a_start: assert property (p_start) else $error("start");
   a_sp: assert property (p_sp) else $error("sp");
   a_irq: assert property (p_irq) else $error("irq");
   a_osc: assert property (p_osc) else $error("osc");
   a_pre: assert property (p_pre) else $error("prescaler");
   a_wdt: assert property (p_wdt) else $error("watchdog");
   a_vdet: assert property (p_vdet) else $error("vdet");
   a_nvm: assert property (p_nvm) else $error("nvm");
endmodule

bind reset_warmup_sequencer rwu_properties u_chk (
   .aclk(aclk), .aresetn(aresetn), .por_req(por_req),
   .pin_reset_n(pin_reset_n), .internal_req(internal_req),
   .serial_prom_mode(serial_prom_mode), .nvm_rd(nvm_rd),
   .cpu_reset(cpu_reset), .periph_reset(periph_reset),
   .program_counter(program_counter), .stack_pointer(stack_pointer),
   .register_bank_select(register_bank_select),
   .interrupt_master_enable(interrupt_master_enable),
   .interrupt_individual_enable(interrupt_individual_enable),
   .interrupt_latch(interrupt_latch), .cpu_fetch_vector(cpu_fetch_vector),
   .vector_addr(vector_addr), .int_osc_en(int_osc_en),
   .ext_hf_osc_en(ext_hf_osc_en), .ext_lf_osc_en(ext_lf_osc_en),
   .prescaler_clr(prescaler_clr), .watchdog_en(watchdog_en),
   .port_oe(port_oe), .vdet_en(vdet_en));

//--- sim/trim_nvm_model.sv
module trim_nvm_model (
   // Memory side
   input wire logic aclk,
   input wire logic [1:0] nvm_addr,
   input wire logic nvm_rd,
   input wire logic corrupt,
   output logic [7:0] nvm_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] junk_ff = 8'h3c;
   always_ff @(posedge aclk) begin
      junk_ff <= ~junk_ff;
   end
   // Check word is the inverse unless corrupted; junk when not read
   assign nvm_data = !nvm_rd ? junk_ff : nvm_addr == 2'h0 ? 8'h5a
      : corrupt ? 8'h5a : 8'ha5;
endmodule

//--- verilog/reset_warmup_sequencer.sv
module reset_warmup_sequencer #(
   parameter int WARMUP_COUNT = rwu_pkg::WARMUP_CYCLES
) (
   // Clock and bus reset
   input wire logic aclk,
   input wire logic aresetn,
   // Reset requests
   input wire logic por_req,
   input wire logic pin_reset_n,
   input wire logic internal_req,
   input wire logic [6:0] internal_cause,
   input wire logic serial_prom_mode,
   // Trim memory
   output logic [rwu_pkg::NVM_AW-1:0] nvm_addr,
   output logic nvm_rd,
   input wire logic [rwu_pkg::TRIM_W-1:0] nvm_data,
   // Core and peripheral state
   output logic cpu_reset,
   output logic periph_reset,
   output logic [15:0] program_counter,
   output logic [15:0] stack_pointer,
   output logic register_bank_select,
   output logic interrupt_master_enable,
   output logic interrupt_individual_enable,
   output logic interrupt_latch,
   output logic cpu_fetch_vector,
   output logic [15:0] vector_addr,
   output logic int_osc_en,
   output logic ext_hf_osc_en,
   output logic ext_lf_osc_en,
   output logic prescaler_clr,
   output logic watchdog_en,
   output logic port_oe,
   output logic vdet_en,
   output logic [rwu_pkg::TRIM_W-1:0] trim_value,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic ext_reset;
   logic any_reset;
   logic wu_done;
   logic [31:0] wu_count;
   rwu_pkg::phase_t phase_ff;
   rwu_pkg::phase_t nxt_phase;
   logic [rwu_pkg::TRIM_W-1:0] trim_ff;
   logic [rwu_pkg::TRIM_W-1:0] trim_chk_ff;
   logic trim_bad_ff;
   logic [6:0] cause_ff;
   logic vdet_en_ff;
   logic clr_arm_ff;
   logic aw_ok_ff;
   logic w_ok_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic wr_fire;
   logic [31:0] wu_cnt_ctr;

   logic wr_ctrl;
   logic wr_cause;
   logic clr_hit;
   logic trim_chk_now;
   logic trim_mismatch;
   logic in_warmup;
   logic in_run;
   logic rd_take;

   assign ext_reset = por_req | ~pin_reset_n;
   assign any_reset = ext_reset | internal_req | ~aresetn;

   warmup_counter #(.COUNT(WARMUP_COUNT)) u_wu (
      .aclk(aclk),
      .clear(any_reset),
      .done(wu_done),
      .count(wu_count)
   );
   assign wu_cnt_ctr = wu_count;

   // Phase decode
   assign in_warmup = (phase_ff == rwu_pkg::PH_WARMUP);
   assign in_run = (phase_ff == rwu_pkg::PH_RUN);

   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         rwu_pkg::PH_RESET: nxt_phase = rwu_pkg::PH_WARMUP;
         rwu_pkg::PH_WARMUP: begin
            if (wu_done) begin
               nxt_phase = rwu_pkg::PH_RUN;
            end
         end
         rwu_pkg::PH_RUN: nxt_phase = rwu_pkg::PH_RUN;
         default: nxt_phase = rwu_pkg::PH_RESET;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (any_reset) begin
         phase_ff <= rwu_pkg::PH_RESET;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // Trim load sequence during warm-up
   // Counter reads 1 in the first warm-up cycle: word, then check word
   assign nvm_rd = in_warmup &&
      (wu_cnt_ctr < 32'(rwu_pkg::TRIM_LOAD_CYCLES));
   assign nvm_addr = (wu_cnt_ctr == 32'h1) ? rwu_pkg::TRIM_ADDR :
      rwu_pkg::TRIM_CHK_ADDR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trim_ff <= '0;
         trim_chk_ff <= '0;
      end else if (nvm_rd && wu_cnt_ctr == 32'h1) begin
         trim_ff <= nvm_data;
      end else if (nvm_rd && wu_cnt_ctr == 32'h2) begin
         trim_chk_ff <= nvm_data;
      end
   end

   // Register write decode
   assign wr_fire = aw_ok_ff && w_ok_ff && !bvalid_ff;
   assign wr_ctrl = wr_fire && (awaddr_ff == rwu_pkg::OFS_CTRL);
   assign wr_cause = wr_fire && (awaddr_ff == rwu_pkg::OFS_CAUSE);
   assign clr_hit = wr_cause && clr_arm_ff &&
      (wdata_ff[7:0] == rwu_pkg::CAUSE_CLEAR_CODE);

   // Trim check point
   assign trim_chk_now = in_warmup &&
      (wu_cnt_ctr == 32'(rwu_pkg::TRIM_LOAD_CYCLES));
   assign trim_mismatch = (trim_chk_ff != ~trim_ff);

   // Trim status, sticky; set wins over software clear
   always_ff @(posedge aclk) begin
      if (!aresetn || ext_reset) begin
         trim_bad_ff <= 1'b0;
      end else if (trim_chk_now && trim_mismatch) begin
         trim_bad_ff <= 1'b1;
      end else if (clr_hit) begin
         trim_bad_ff <= 1'b0;
      end
   end

   // Cause flags: internal resets never clear them
   always_ff @(posedge aclk) begin
      if (!aresetn || ext_reset) begin
         cause_ff <= 7'h00;
      end else if (internal_req) begin
         cause_ff <= cause_ff | internal_cause;
      end else if (clr_hit) begin
         cause_ff <= 7'h00;
      end
   end

   // Arm bit, then clear code
   always_ff @(posedge aclk) begin
      if (!aresetn || any_reset) begin
         clr_arm_ff <= 1'b0;
      end else if (wr_ctrl) begin
         clr_arm_ff <= wdata_ff[0];
      end else if (wr_cause) begin
         clr_arm_ff <= 1'b0;
      end
   end

   // Voltage detector enable
   always_ff @(posedge aclk) begin
      if (!aresetn || ext_reset) begin
         vdet_en_ff <= 1'b0;
      end else if (wr_ctrl) begin
         vdet_en_ff <= wdata_ff[1];
      end
   end

   // Core and peripheral outputs
   assign cpu_reset = !in_run;
   assign periph_reset = !in_run;
   assign program_counter = serial_prom_mode ? rwu_pkg::PC_SPROM :
      rwu_pkg::PC_NORMAL;
   assign cpu_fetch_vector = in_warmup && wu_done;
   assign vector_addr = rwu_pkg::VECTOR_LO;

   // CPU register defaults
   // No RAM, general registers or ALU flags kept here
   assign stack_pointer = rwu_pkg::SP_RESET;
   assign register_bank_select = 1'b0;

   // Interrupt state
   assign interrupt_master_enable = 1'b0;
   assign interrupt_individual_enable = 1'b0;
   assign interrupt_latch = 1'b0;

   // Oscillators and timers
   assign int_osc_en = 1'b1;
   assign ext_hf_osc_en = 1'b0;
   assign ext_lf_osc_en = 1'b0;
   assign prescaler_clr = !in_run;

   // Watchdog and ports
   assign watchdog_en = in_run;
   assign port_oe = 1'b0;

   // Status from flip-flops
   assign vdet_en = vdet_en_ff;
   assign trim_value = trim_ff;

   // AXI write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_ff <= 1'b0;
         awaddr_ff <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_ok_ff <= 1'b1;
         awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_ok_ff <= 1'b0;
      end
   end

   // AXI write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_ok_ff <= 1'b0;
         wdata_ff <= 32'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_ok_ff <= 1'b1;
         wdata_ff <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end else if (wr_fire) begin
         w_ok_ff <= 1'b0;
      end
   end
   assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
   assign s_axi_wready = !w_ok_ff && !bvalid_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'h0;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (awaddr_ff == rwu_pkg::OFS_CTRL ||
            awaddr_ff == rwu_pkg::OFS_CAUSE) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // AXI read channel
   assign s_axi_arready = !rvalid_ff;
   assign rd_take = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= 2'h0;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= 2'h0;
         case (s_axi_araddr)
            rwu_pkg::OFS_CTRL: rdata_ff <= {30'h0, vdet_en_ff, clr_arm_ff};
            rwu_pkg::OFS_STATUS: rdata_ff <= {27'h0, vdet_en_ff, trim_bad_ff,
               phase_ff == rwu_pkg::PH_RUN, phase_ff == rwu_pkg::PH_WARMUP,
               phase_ff == rwu_pkg::PH_RESET};
            rwu_pkg::OFS_TRIM: rdata_ff <= {24'h0, trim_ff};
            rwu_pkg::OFS_CAUSE: rdata_ff <= {25'h0, cause_ff};
            default: begin
               rdata_ff <= 32'h0;
               rresp_ff <= 2'h2;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
endmodule

//--- verilog/rwu_pkg.sv
package rwu_pkg;
   localparam logic [15:0] PC_NORMAL = 16'hfffe;
   localparam logic [15:0] PC_SPROM = 16'h1ffe;
   localparam logic [15:0] VECTOR_LO = 16'hfffe;
   localparam logic [15:0] SP_RESET = 16'h00ff;
   localparam int WARMUP_CYCLES = 4096;
   localparam int TRIM_W = 8;
   localparam int NVM_AW = 2;
   localparam logic [NVM_AW-1:0] TRIM_ADDR = 2'h0;
   localparam logic [NVM_AW-1:0] TRIM_CHK_ADDR = 2'h1;
   localparam int TRIM_LOAD_CYCLES = 3;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_TRIM = 12'h008;
   localparam logic [11:0] OFS_CAUSE = 12'h00c;
   localparam logic [7:0] CAUSE_CLEAR_CODE = 8'h71;
   localparam int ST_RESET = 0;
   localparam int ST_WARMUP = 1;
   localparam int ST_RUN = 2;
   localparam int ST_TRIM_BAD = 3;
   localparam int ST_VDET_EN = 4;
   typedef enum logic [1:0] {PH_RESET, PH_WARMUP, PH_RUN} phase_t;
endpackage

//--- verilog/warmup_counter.sv
module warmup_counter #(
   parameter int COUNT = rwu_pkg::WARMUP_CYCLES
) (
   // Clock and control
   input wire logic aclk,
   input wire logic clear,
   // Status
   output logic done,
   output logic [31:0] count
);
   logic [31:0] count_ff;
   always_ff @(posedge aclk) begin
      if (clear) begin
         count_ff <= 32'h0;
      end else if (count_ff < 32'(COUNT)) begin
         count_ff <= count_ff + 32'h1;
      end
   end
   assign done = (count_ff >= 32'(COUNT));
   assign count = count_ff;
endmodule
